/* File: hw/sra_device.sv */
// Behaviour
// - Frames are 16, 24 or 32 clocks
// - Command byte: 7-bit address, write bit
// - First output byte is global interrupt summary
// - Summary bit 7 driven at select fall
// - Write returns old register contents
// - Read returns contents, registers unchanged
// - Burst read walks consecutive addresses
// - Input sampled on serial clock rise
// - Output changes on serial clock fall
// - Clock count sets bytes written, consecutively
// - Host gives at least 16 clocks; the host here sends whatever count the command sets
// - Writes commit on deselect, exact count or 31 clocks
// - 31 clocks store two bytes only
// - Wrong clock count sets framing error
// - Output floats while deselected
// - Sleep mode ignores transactions
// - Host waits 2 us after write
// - Normal/silent: receive output follows bus
// - Standby/sleep: receive low only on wake
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module sra_device
	import sra_pkg::*;
(
	input  wire logic       clk_in,          // System clock, 125 MHz.
	input  wire logic       srst_in,         // Synchronous reset, active high.
	sra_if.dev              link,            // Serial link to the host.
	input  wire sra_mode_e  mode_in,         // Current operating mode.
	input  wire logic       bus_dominant_in, // Bus seen dominant.
	input  wire logic       wake_event_in,   // Wake-up event present.
	input  wire logic [7:0] gis_in,          // Global interrupt summary value.
	input  wire logic       err_clear_in,    // Clears the framing error flag.
	output logic            serial_framing_error_flag_out, // Sticky framing error.
	output logic            commit_out,      // Pulse when a write is stored.
	output logic [6:0]      commit_addr_out  // First address of last stored write.
);

	logic [2:0]  cs_s;        // Select synchroniser plus edge stage.
	logic [2:0]  sck_s;       // Clock synchroniser plus edge stage.
	logic [1:0]  sdi_s;       // Data synchroniser.
	logic        active_r;    // Frame accepted, not in sleep.
	logic [5:0]  cnt_r;       // Serial clocks seen, saturating.
	logic [31:0] in_sr_r;     // Incoming bits.
	logic [6:0]  addr_r;      // Commanded address.
	logic        wr_r;        // Commanded direction.
	logic [7:0]  out_sr_r;    // Remaining bits of the current output byte.
	logic        sdo_r;       // Output bit.
	logic        oe_n_r;      // Output enable, low while driving.
	logic        rxd_r;       // Receive output.
	logic        err_r;       // Framing error flag.
	logic        commit_r;    // Commit pulse.
	logic [6:0]  caddr_r;     // Commit address.
	logic [7:0]  mem_r [0:SRA_REG_COUNT-1]; // Register store.

	logic        cs_fall;     // Select went low.
	logic        cs_rise;     // Select went high.
	logic        sck_rise;    // Serial clock rose inside a frame.
	logic        sck_fall;    // Serial clock fell inside a frame.
	logic        exact;       // Frame length is one of the legal ones.
	logic [1:0]  nbytes;      // Bytes to store at deselect.
	logic [31:0] aligned;     // Data bytes left-justified under the command.
	logic [7:0]  byte_load;   // Register byte for the coming data slot.

	// Reads a register; the summary address is live hardware state.
	function automatic logic [7:0] rd_byte(input logic [6:0] a);
		rd_byte = (a == SRA_GIS_ADDR) ? gis_in : mem_r[a];
	endfunction : rd_byte

	// Tells whether a clock count is a legal frame length.
	function automatic logic is_exact(input logic [5:0] n);
		is_exact = (n == SRA_BITS_MIN) || (n == SRA_BITS_MID) || (n == SRA_BITS_MAX);
	endfunction : is_exact

	// Pin inputs pass two flip-flops; the third stage only serves edge detection.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			cs_s  <= 3'h7;
			sck_s <= 3'h0;
			sdi_s <= 2'h0;
		end
		else
		begin
			cs_s  <= {cs_s[1:0], link.chip_select_n};
			sck_s <= {sck_s[1:0], link.sclk};
			sdi_s <= {sdi_s[0], link.sdi};
		end
	end

	assign cs_fall  = cs_s[2] & ~cs_s[1];
	assign cs_rise  = ~cs_s[2] & cs_s[1];
	assign sck_rise = ~sck_s[2] & sck_s[1] & ~cs_s[1] & active_r;
	assign sck_fall = sck_s[2] & ~sck_s[1] & ~cs_s[1] & active_r;
	assign exact    = is_exact(cnt_r);

	// Left-justify the data so byte k sits at bits 23-8k.
	assign aligned = in_sr_r << (SRA_BITS_MAX - cnt_r);

	// Byte for the coming slot; slot k reads the commanded address plus k minus one.
	// It is only loaded at a byte boundary, so it sees the contents before any commit.
	assign byte_load = rd_byte(addr_r + 7'(cnt_r[5:3] - 3'h1));

	// Byte count to store; a 31-clock burst drops only its partial third byte.
	always_comb
	begin
		nbytes = 2'h0;
		if (exact)
			nbytes = 2'((cnt_r - SRA_BITS_CMD) >> 3);
		else if (cnt_r == SRA_BITS_TRIM)
			nbytes = 2'h2;
	end

	// Frame acceptance; a frame that starts in sleep is ignored to its end.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			active_r <= 1'b0;
		else if (cs_fall)
			active_r <= (mode_in != SRA_MODE_SLEEP);
		else if (cs_rise)
			active_r <= 1'b0;
	end

	// Input side: count clocks and sample data on each rising serial edge.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			cnt_r   <= 6'h00;
			in_sr_r <= 32'h0000_0000;
			addr_r  <= 7'h00;
			wr_r    <= 1'b0;
		end
		else if (cs_fall)
			cnt_r <= 6'h00;
		else if (sck_rise)
		begin
			in_sr_r <= {in_sr_r[30:0], sdi_s[1]};
			if (cnt_r != SRA_BITS_OVER)
				cnt_r <= cnt_r + 6'h01;
			if (cnt_r == SRA_BITS_CMD - 6'h01)
			begin
				addr_r <= in_sr_r[6:0];
				wr_r   <= sdi_s[1];
			end
		end
	end

	// Output side: summary byte first, then the addressed bytes.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			sdo_r    <= 1'b1;
			oe_n_r   <= 1'b1;
			out_sr_r <= 8'h00;
		end
		else if (cs_fall && (mode_in != SRA_MODE_SLEEP))
		begin
			sdo_r    <= gis_in[7];
			out_sr_r <= {gis_in[6:0], 1'b0};
			oe_n_r   <= 1'b0;
		end
		else if (cs_rise)
			oe_n_r <= 1'b1;
		else if (sck_fall)
		begin
			if ((cnt_r[2:0] == 3'h0) && (cnt_r != 6'h00) && (cnt_r < SRA_BITS_MAX))
			begin
				sdo_r    <= byte_load[7];
				out_sr_r <= {byte_load[6:0], 1'b0};
			end
			else
			begin
				sdo_r    <= out_sr_r[7];
				out_sr_r <= {out_sr_r[6:0], 1'b0};
			end
		end
	end

	// Write commit at deselect. The summary address is read-only and skipped.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			for (int i = 0; i < SRA_REG_COUNT; i++)
				mem_r[i] <= 8'h00;
			commit_r <= 1'b0;
			caddr_r  <= 7'h00;
		end
		else
		begin
			commit_r <= 1'b0;
			if (cs_rise && active_r && wr_r && (nbytes != 2'h0))
			begin
				commit_r <= 1'b1;
				caddr_r  <= addr_r;
				for (int k = 0; k < 3; k++)
				begin
					if ((2'(k) < nbytes) && ((addr_r + 7'(k)) != SRA_GIS_ADDR))
						mem_r[addr_r + 7'(k)] <= aligned[23 - 8*k -: 8];
				end
			end
		end
	end

	// Framing error flag. A new error in the clearing cycle keeps the flag set.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			err_r <= 1'b0;
		else if (cs_rise && active_r && !exact)
			err_r <= 1'b1;
		else if (err_clear_in)
			err_r <= 1'b0;
	end

	// Receive output. Bus inputs come from on-chip logic on this clock.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			rxd_r <= 1'b1;
		else if ((mode_in == SRA_MODE_NORMAL) || (mode_in == SRA_MODE_SILENT))
			rxd_r <= ~bus_dominant_in;
		else
			rxd_r <= ~wake_event_in;
	end

	assign link.sdo_val                  = sdo_r;
	assign link.sdo_oe_n                 = oe_n_r;
	assign link.rxd                      = rxd_r;
	assign serial_framing_error_flag_out = err_r;
	assign commit_out                    = commit_r;
	assign commit_addr_out               = caddr_r;

endmodule : sra_device

/* File: hw/sra_pkg.sv */
package sra_pkg;
	// Frame lengths in serial clocks.
	localparam logic [5:0] SRA_BITS_CMD  = 6'h08;
	localparam logic [5:0] SRA_BITS_MIN  = 6'h10;
	localparam logic [5:0] SRA_BITS_MID  = 6'h18;
	localparam logic [5:0] SRA_BITS_MAX  = 6'h20;
	localparam logic [5:0] SRA_BITS_TRIM = 6'h1F;
	localparam logic [5:0] SRA_BITS_OVER = 6'h21;
	// Register addresses and field positions.
	localparam logic [6:0] SRA_GIS_ADDR  = 7'h50;
	localparam int         SRA_WR_BIT    = 0;
	localparam int         SRA_REG_COUNT = 128;
	// Host clock divider: half period of the serial clock in clk_in cycles.
	localparam logic [3:0] SRA_HALF_CYC  = 4'h8;
	// Host pause after a write so the global status can settle.
	localparam int         SRA_CLK_NS     = 8;
	localparam int         SRA_WR_GAP_NS  = 2000;
	localparam int         SRA_WR_GAP_INT = (SRA_WR_GAP_NS + SRA_CLK_NS - 1) / SRA_CLK_NS;
	localparam logic [8:0] SRA_WR_GAP_CYC = SRA_WR_GAP_INT[8:0];
	// Host command registers on APB, byte addresses.
	localparam logic [7:0] SRA_OFS_CMD    = 8'h00;
	localparam logic [7:0] SRA_OFS_WDATA  = 8'h04;
	localparam logic [7:0] SRA_OFS_STATUS = 8'h08;
	localparam logic [7:0] SRA_OFS_RDATA  = 8'h0C;
	// Device operating modes.
	typedef enum logic [1:0]
	{
		SRA_MODE_NORMAL,
		SRA_MODE_SILENT,
		SRA_MODE_STANDBY,
		SRA_MODE_SLEEP
	} sra_mode_e;
endpackage : sra_pkg

/* File: hw/sra_if.sv */
`timescale 1ns/1ps
interface sra_if;
	logic chip_select_n; // Frame select, low while a transaction runs.
	logic sclk;          // Serial clock from the host.
	logic sdi;           // Host to device data.
	logic sdo_val;       // Device output value.
	logic sdo_oe_n;      // Device output enable, low while driving.
	logic rxd;           // Receive output of the transceiver.
	wire  sdo_line;      // Resolved serial output wire.

	// With no driver the line rests at the level of its pull-up, so a
	// deselected device reads as ones rather than as the last bit it sent.
	assign sdo_line = sdo_oe_n ? 1'b1 : sdo_val;

	modport dev  (input chip_select_n, sclk, sdi, output sdo_val, sdo_oe_n, rxd);
	modport host (output chip_select_n, sclk, sdi, input sdo_line, rxd);
endinterface : sra_if

/* File: hw/sra_host.sv */
`timescale 1ns/1ps
module sra_host
	import sra_pkg::*;
(
	input  wire logic        clk_in,      // System clock, 125 MHz.
	input  wire logic        srst_in,     // Synchronous reset, active high.
	input  wire logic        psel_in,     // APB select.
	input  wire logic        penable_in,  // APB enable.
	input  wire logic        pwrite_in,   // APB direction.
	input  wire logic [7:0]  paddr_in,    // APB byte address.
	input  wire logic [31:0] pwdata_in,   // APB write data.
	output logic [31:0]      prdata_out,  // APB read data.
	output logic             pready_out,  // APB ready.
	output logic             pslverr_out, // APB error, unmapped address.
	sra_if.host              link         // Serial link to the device.
);

	typedef enum logic [2:0] {SRA_H_IDLE, SRA_H_LEAD, SRA_H_LOW, SRA_H_HIGH, SRA_H_GAP} sra_hst_e;

	sra_hst_e    st_r;       // Serial sequencer state.
	logic [3:0]  div_r;      // Half period counter of the generated clock.
	logic [8:0]  gap_r;      // Pause counter after a frame.
	logic [5:0]  nbits_r;    // Clocks to send in this frame.
	logic [5:0]  sent_r;     // Clocks sent so far.
	logic [31:0] tx_r;       // Outgoing bits, MSB first.
	logic [31:0] rx_r;       // Incoming bits.
	logic [31:0] rdata_r;    // Last frame's received bits, left-justified.
	logic [31:0] cmd_r;      // Command register.
	logic [23:0] wdata_r;    // Write data register.
	logic        wr_r;       // Frame in flight is a write.
	logic        cs_n_r;     // Select pin.
	logic        sck_r;      // Clock pin.
	logic        sdi_r;      // Data pin.
	logic [1:0]  sdo_s;      // Output pin synchroniser.
	logic        pready_r;   // Ready, one wait state.
	logic [31:0] prdata_r;   // Read data.
	logic        pslverr_r;  // Error answer.
	logic        go;         // Accepted command write.
	logic        apb_done;   // Access completes this edge.

	assign apb_done = psel_in & penable_in & pready_r;
	assign go       = apb_done & pwrite_in & (paddr_in == SRA_OFS_CMD) & (st_r == SRA_H_IDLE);

	// APB slave; each access takes one wait state.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
			cmd_r     <= 32'h0000_0000;
			wdata_r   <= 24'h00_0000;
		end
		else
		begin
			pready_r <= psel_in & penable_in & ~pready_r;
			if (psel_in && penable_in && !pready_r)
			begin
				pslverr_r <= 1'b0;
				case (paddr_in)
					SRA_OFS_CMD:    prdata_r <= cmd_r;
					SRA_OFS_WDATA:  prdata_r <= {8'h00, wdata_r};
					SRA_OFS_STATUS: prdata_r <= {31'h0000_0000, (st_r != SRA_H_IDLE)};
					SRA_OFS_RDATA:  prdata_r <= rdata_r;
					default:
					begin
						prdata_r  <= 32'h0000_0000;
						pslverr_r <= 1'b1;
					end
				endcase
			end
			if (apb_done && pwrite_in && (paddr_in == SRA_OFS_CMD))
				cmd_r <= pwdata_in;
			if (apb_done && pwrite_in && (paddr_in == SRA_OFS_WDATA))
				wdata_r <= pwdata_in[23:0];
		end
	end

	// Output pin value passes two flip-flops before use.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			sdo_s <= 2'h0;
		else
			sdo_s <= {sdo_s[0], link.sdo_line};
	end

	// Serial sequencer: clock made by dividing clk_in, data set while low.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			st_r    <= SRA_H_IDLE;
			div_r   <= 4'h0;
			gap_r   <= 9'h000;
			nbits_r <= 6'h00;
			sent_r  <= 6'h00;
			tx_r    <= 32'h0000_0000;
			rx_r    <= 32'h0000_0000;
			rdata_r <= 32'h0000_0000;
			wr_r    <= 1'b0;
			cs_n_r  <= 1'b1;
			sck_r   <= 1'b0;
			sdi_r   <= 1'b0;
		end
		else
		begin
			div_r <= div_r + 4'h1;
			case (st_r)
				SRA_H_IDLE:
				begin
					if (go)
					begin
						// Zero count means the nominal length for three bytes.
						nbits_r <= (pwdata_in[13:8] == 6'h00) ? SRA_BITS_MAX : pwdata_in[13:8];
						tx_r    <= {pwdata_in[6:0], pwdata_in[7], wdata_r};
						wr_r    <= pwdata_in[7];
						sent_r  <= 6'h00;
						cs_n_r  <= 1'b0;
						div_r   <= 4'h0;
						st_r    <= SRA_H_LEAD;
					end
				end
				SRA_H_LEAD, SRA_H_LOW:
				begin
					if (div_r == SRA_HALF_CYC - 4'h1)
					begin
						div_r <= 4'h0;
						if (sent_r == nbits_r)
						begin
							cs_n_r  <= 1'b1;
							rdata_r <= rx_r << (SRA_BITS_MAX - nbits_r);
							// settle pause after write
							// The status needs time to settle after a write.
							gap_r   <= wr_r ? SRA_WR_GAP_CYC : 9'(SRA_HALF_CYC);
							st_r    <= SRA_H_GAP;
						end
						else
						begin
							sck_r <= 1'b1;
							st_r  <= SRA_H_HIGH;
						end
					end
					else if ((div_r == 4'h0) && (sent_r != nbits_r))
						sdi_r <= tx_r[31];
				end
				SRA_H_HIGH:
				begin
					if (div_r == SRA_HALF_CYC - 4'h1)
					begin
						div_r  <= 4'h0;
						sck_r  <= 1'b0;
						rx_r   <= {rx_r[30:0], sdo_s[1]};
						tx_r   <= {tx_r[30:0], 1'b0};
						sent_r <= sent_r + 6'h01;
						st_r   <= SRA_H_LOW;
					end
				end
				SRA_H_GAP:
				begin
					if (gap_r == 9'h000)
						st_r <= SRA_H_IDLE;
					else
						gap_r <= gap_r - 9'h001;
				end
				default: st_r <= SRA_H_IDLE;
			endcase
		end
	end

	assign link.chip_select_n = cs_n_r;
	assign link.sclk          = sck_r;
	assign link.sdi           = sdi_r;
	assign prdata_out         = prdata_r;
	assign pready_out         = pready_r;
	assign pslverr_out        = pslverr_r;

endmodule : sra_host

/* File: verif/sra_check_sva.sv */
`timescale 1ns/1ps
// Watches the serial link between the two ends of the port.
module sra_check
	import sra_pkg::*;
(
	input wire logic       clk_in,          // System clock.
	input wire logic       srst_in,         // Reset, active high.
	input wire logic       chip_select_n,   // Frame select.
	input wire logic       sclk,            // Serial clock.
	input wire logic       sdo_val,         // Device output value.
	input wire logic       sdo_oe_n,        // Device drives when low.
	input wire logic       rxd,             // Receive output.
	input wire sra_mode_e  mode_in,         // Device mode.
	input wire logic       bus_dominant_in, // Bus is dominant.
	input wire logic       wake_event_in,   // Wake event present.
	input wire logic [7:0] gis_in,          // Summary value.
	input wire logic       err_clear_in,    // Flag clear.
	input wire logic       serial_framing_error_flag_out, // Sticky flag.
	input wire logic       commit_out       // Write stored.
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	logic [3:0] since_fall_r; // Cycles since the last serial clock fall.
	logic       sleep_frm_r;  // Current frame began in sleep mode.

	// Counts up from each serial clock fall and saturates.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			since_fall_r <= 4'h0;
		else if ($fell(sclk))
			since_fall_r <= 4'h0;
		else if (since_fall_r != 4'hF)
			since_fall_r <= since_fall_r + 4'h1;
	end

	// Remembers whether the frame opened while asleep.
	always_ff @(posedge clk_in)
	begin
		if (srst_in || chip_select_n)
			sleep_frm_r <= 1'b0;
		else if ($fell(chip_select_n))
			sleep_frm_r <= (mode_in == SRA_MODE_SLEEP);
	end

	sequence s_sel_awake;
		$fell(chip_select_n) && mode_in != SRA_MODE_SLEEP;
	endsequence
	sequence s_first_bit;
		##[1:6] (!sdo_oe_n && sdo_val == gis_in[7]);
	endsequence
	property p_first_bit;
		s_sel_awake |-> s_first_bit;
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("first bit late or wrong");
	// A deselected device must have let go of the line by now.
	property p_float;
		chip_select_n [*6] |-> sdo_oe_n;
	endproperty
	a_float: assert property (p_float) else $error("output driven while idle");
	property p_sleep;
		sleep_frm_r |-> sdo_oe_n;
	endproperty
	a_sleep: assert property (p_sleep) else $error("output driven in sleep");
	// Synchroniser delay is small, far below the half period.
	property p_sdo_fall;
		$changed(sdo_val) && !sdo_oe_n && !$past(sdo_oe_n) |-> since_fall_r <= 4'h6;
	endproperty
	a_sdo_fall: assert property (p_sdo_fall) else $error("output moved off a fall");
	property p_rx_act;
		!$past(srst_in) && mode_in inside {SRA_MODE_NORMAL, SRA_MODE_SILENT}
		&& $past(mode_in) == mode_in |-> rxd == !$past(bus_dominant_in);
	endproperty
	a_rx_act: assert property (p_rx_act) else $error("receive output wrong");
	property p_rx_low;
		!$past(srst_in) && mode_in inside {SRA_MODE_STANDBY, SRA_MODE_SLEEP}
		&& $past(mode_in) == mode_in |-> rxd == !$past(wake_event_in);
	endproperty
	a_rx_low: assert property (p_rx_low) else $error("low power receive wrong");
	property p_flag_keep;
		serial_framing_error_flag_out && !err_clear_in |=> serial_framing_error_flag_out;
	endproperty
	a_flag_keep: assert property (p_flag_keep) else $error("error flag lost");
	property p_flag_rise;
		$rose(serial_framing_error_flag_out) |-> chip_select_n && $past(chip_select_n);
	endproperty
	a_flag_rise: assert property (p_flag_rise) else $error("flag set mid frame");
	property p_commit;
		commit_out |-> chip_select_n && $past(chip_select_n, 2);
	endproperty
	a_commit: assert property (p_commit) else $error("store before deselect");
endmodule : sra_check

/* File: verif/sra_test.sv */
`timescale 1ns/1ps
// Host and device face each other; software talks to the host over APB.
module sra_test
	import sra_pkg::*;
;
	logic        clk_in = 1'b0;     // System clock.
	logic        srst_in = 1'b1;    // Reset.
	logic        psel_in = 1'b0;    // APB select.
	logic        penable_in = 1'b0; // APB enable.
	logic        pwrite_in = 1'b0;  // APB direction.
	logic [7:0]  paddr_in = 8'h00;  // APB address.
	logic [31:0] pwdata_in = 32'h0; // APB write data.
	logic [31:0] prdata_out;        // APB read data.
	logic        pready_out;        // APB ready.
	logic        pslverr_out;       // APB error.
	sra_mode_e   mode_in = SRA_MODE_NORMAL; // Device mode.
	logic        bus_dominant_in = 1'b0;    // Bus state.
	logic        wake_event_in = 1'b0;      // Wake event.
	logic        err_clear_in = 1'b0;       // Flag clear.
	logic [7:0]  gis_in = 8'hA5;    // Summary value, top bit set.
	logic        flag_out;          // Framing error flag.
	logic        commit_out;        // Store pulse.
	logic [6:0]  commit_addr_out;   // Store address.
	int          err_total = 0;     // Mismatches.
	int          check_count = 0;   // Comparisons.
	int          commits = 0;       // Store pulses seen.

	// Free running clock, 8 ns period.
	always #4 clk_in = ~clk_in;

	sra_if u_sra_if ();
	sra_host u_sra_host (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .link(u_sra_if.host));
	sra_device u_sra_device (.clk_in(clk_in), .srst_in(srst_in), .link(u_sra_if.dev),
		.mode_in(mode_in), .bus_dominant_in(bus_dominant_in),
		.wake_event_in(wake_event_in), .gis_in(gis_in), .err_clear_in(err_clear_in),
		.serial_framing_error_flag_out(flag_out), .commit_out(commit_out),
		.commit_addr_out(commit_addr_out));
	sra_check u_sra_check (.clk_in(clk_in), .srst_in(srst_in),
		.chip_select_n(u_sra_if.chip_select_n), .sclk(u_sra_if.sclk),
		.sdo_val(u_sra_if.sdo_val), .sdo_oe_n(u_sra_if.sdo_oe_n), .rxd(u_sra_if.rxd),
		.mode_in(mode_in), .bus_dominant_in(bus_dominant_in),
		.wake_event_in(wake_event_in), .gis_in(gis_in), .err_clear_in(err_clear_in),
		.serial_framing_error_flag_out(flag_out), .commit_out(commit_out));

	// Counts store pulses so missing or extra stores show.
	always @(posedge clk_in)
		if (commit_out === 1'b1)
			commits++;

	// Ends the run with the counts and the verdict.
	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			$display("BAD %s exp %h seen %h", nm, exp, seen);
			err_total++;
		end
	endtask : chk

	// One APB transfer; waits up to 50 cycles for ready.
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (pready_out !== 1'b1 && n < 50);
		if (n >= 50)
			err_total++;
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb

	// Runs one serial frame and returns the received bits.
	task frame(input logic wr, input logic [6:0] a, input logic [5:0] cnt,
		input logic [23:0] d, output logic [31:0] rx);
		logic [31:0] st;
		logic        er;
		int          n;
		apb(1'b1, SRA_OFS_WDATA, {8'h00, d}, st, er);
		apb(1'b1, SRA_OFS_CMD, {18'h00000, cnt, wr, a}, st, er);
		n = 0;
		// Busy also covers the host's pause after a write.
		do
		begin
			apb(1'b0, SRA_OFS_STATUS, 32'h0, st, er);
			n++;
		end
		while (st[0] !== 1'b0 && n < 500);
		if (n >= 500)
			err_total++;
		apb(1'b0, SRA_OFS_RDATA, 32'h0, rx, er);
	endtask : frame

	task clr_flag;
		err_clear_in <= 1'b1;
		@(posedge clk_in);
		err_clear_in <= 1'b0;
		@(posedge clk_in);
		chk("flag clear", {31'h0, flag_out}, 32'h1 - 32'h1);
	endtask : clr_flag

	// Main sequence.
	initial
	begin
		logic [31:0] rx;
		logic        er;
		logic [5:0]  bad [2];
		bad = '{6'h14, 6'h08};
		repeat (20) @(posedge clk_in);
		srst_in <= 1'b0;
		apb(1'b0, SRA_OFS_STATUS, 32'h0, rx, er);
		chk("status reset", rx, 32'h0);
		apb(1'b0, SRA_OFS_RDATA, 32'h0, rx, er);
		chk("rdata reset", rx, 32'h0);
		apb(1'b0, 8'h10, 32'h0, rx, er);
		chk("unmapped", {rx[30:0], er}, 32'h1);
		chk("sdo idle", {30'h0, u_sra_if.sdo_oe_n, u_sra_if.sdo_line}, 32'h3);
		frame(1'b0, SRA_GIS_ADDR, SRA_BITS_MIN, 24'h0, rx);
		chk("summary", {16'h0, rx[31:16]}, 32'hA5A5);
		frame(1'b1, 7'h20, SRA_BITS_MAX, 24'h112233, rx);
		chk("write old", rx, 32'hA5000000);
		chk("store addr", {25'h0, commit_addr_out}, 32'h20);
		frame(1'b0, 7'h20, SRA_BITS_MAX, 24'h0, rx);
		chk("burst read", rx, 32'hA5112233);
		frame(1'b1, 7'h20, SRA_BITS_MID, 24'h445500, rx);
		chk("write mid", {8'h0, rx[31:8]}, 32'hA51122);
		frame(1'b0, 7'h20, SRA_BITS_MAX, 24'h0, rx);
		chk("mid stored", rx, 32'hA5445533);
		// Sleep frames must leave no trace.
		mode_in <= SRA_MODE_SLEEP;
		frame(1'b1, 7'h60, SRA_BITS_MIN, 24'hAB0000, rx);
		// An undriven line reads high through its pull-up.
		chk("sleep quiet", {16'h0, rx[31:16]}, 32'hFFFF);
		mode_in <= SRA_MODE_NORMAL;
		frame(1'b0, 7'h60, SRA_BITS_MIN, 24'h0, rx);
		chk("sleep store", {16'h0, rx[31:16]}, 32'hA500);
		chk("sleep flag", {31'h0, flag_out}, 32'h0);
		chk("stores", commits, 32'h2);
		frame(1'b1, 7'h30, SRA_BITS_TRIM, 24'h667788, rx);
		chk("trim flag", {31'h0, flag_out}, 32'h1);
		frame(1'b0, 7'h30, SRA_BITS_MAX, 24'h0, rx);
		chk("trim store", rx, 32'hA5667700);
		clr_flag();
		// Short and odd lengths store nothing.
		for (int m = 0; m < 2; m++)
		begin
			frame(1'b1, 7'h40, bad[m], 24'h990000, rx);
			chk("bad flag", {31'h0, flag_out}, 32'h1);
			clr_flag();
			frame(1'b0, 7'h40, SRA_BITS_MIN, 24'h0, rx);
			chk("bad store", {16'h0, rx[31:16]}, 32'hA500);
		end
		chk("stores", commits, 32'h3);
		// A summary with its top bit clear shows that the first bit is live.
		gis_in <= 8'h3C;
		frame(1'b0, SRA_GIS_ADDR, SRA_BITS_MIN, 24'h0, rx);
		chk("summary low", {16'h0, rx[31:16]}, 32'h3C3C);
		// Receive output in every mode.
		for (int m = 0; m < 8; m++)
		begin
			mode_in <= sra_mode_e'(m[2:1]);
			bus_dominant_in <= m[0];
			wake_event_in <= ~m[0];
			repeat (3) @(posedge clk_in);
			chk("rxd", {31'h0, u_sra_if.rxd}, {31'h0, m[2] ? m[0] : ~m[0]});
		end
		give_verdict();
	end

	// Cuts a hang short, well past the expected run length.
	initial
	begin
		repeat (60000) @(posedge clk_in);
		err_total++;
		give_verdict();
	end
endmodule : sra_test
